// ### pkg/sdrtc_if.sv
// register and refresh link between the timer and its controller
`timescale 1ns/1ps
interface sdrtc_if;
    logic req;
    logic write;
    logic [1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    logic refresh_enable;
    logic refresh_req;
    logic [3:0] burst_len;
    logic refresh_done;

    modport dev (input req, write, addr, wdata, refresh_enable, refresh_done,
                 output rdata, ack, refresh_req, burst_len);
    modport ctl (output req, write, addr, wdata, refresh_enable, refresh_done,
                 input rdata, ack, refresh_req, burst_len);
endinterface

// ### pkg/sdrtc_pkg.sv
// constants, types and helper functions shared by both ends of the refresh timer link
package sdrtc_pkg;

    // ==========================================================
    // device register indices on the link
    localparam logic [1:0] REG_CSR = 2'h0;
    localparam logic [1:0] REG_CNT = 2'h1;
    localparam logic [1:0] REG_COR = 2'h2;

    // ==========================================================
    // control/status layout and write protection
    localparam logic [15:0] WRITE_KEY = 16'ha55a;
    localparam int KEY_LSB = 16;
    localparam int KEY_MSB = 31;
    localparam int CMF_BIT = 7;
    localparam int CKS_LSB = 3;
    localparam int RRC_LSB = 0;
    localparam logic [31:0] CSR_RESET = 32'h0000_0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ==========================================================
    // prescaler masks: a tick when all masked bits are ones
    localparam logic [11:0] DIV_STOP = 12'h000;
    localparam logic [11:0] DIV_4 = 12'h003;
    localparam logic [11:0] DIV_16 = 12'h00f;
    localparam logic [11:0] DIV_64 = 12'h03f;
    localparam logic [11:0] DIV_256 = 12'h0ff;
    localparam logic [11:0] DIV_1024 = 12'h3ff;
    localparam logic [11:0] DIV_2048 = 12'h7ff;
    localparam logic [11:0] DIV_4096 = 12'hfff;

    // ==========================================================
    // controller register map (byte offsets on apb)
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_RDATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam int CMD_WRITE_BIT = 8;
    localparam int STS_XFER = 0;
    localparam int STS_REFRESH = 1;
    localparam int STS_BUSY = 2;

    // ==========================================================
    // refresh command spacing
    localparam int CLK_PERIOD_NS = 50;
    localparam int REF_CYCLE_NS = 60;
    localparam logic [1:0] REF_GAP_CYC = 2'((REF_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef logic [7:0] sdrtc_byte_t;
    typedef logic [3:0] sdrtc_burst_t;

    // number of refresh commands for a burst code; prohibited codes give one
    function automatic sdrtc_burst_t sdrtc_burst_len(input logic [2:0] code);
        case (code)
            3'h1: return 4'h2;
            3'h2: return 4'h4;
            3'h3: return 4'h6;
            3'h4: return 4'h8;
            default: return 4'h1;
        endcase
    endfunction

endpackage

// ### rtl/sdrtc_ctrl.sv
// controller end: apb registers, link master and refresh burst sequencer
`timescale 1ns/1ps
module sdrtc_ctrl
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // interrupt and refresh command
    output logic IRQ,
    output logic SDRAM_REFRESH_CMD,
    // link to the timer
    sdrtc_if.ctl LINK,
    // burst length seen at link, for observation
    output sdrtc_pkg::sdrtc_burst_t BURST_LEN
);
    import sdrtc_pkg::*;

    typedef enum logic [1:0] {R_IDLE, R_CMD, R_GAP, R_DONE} sdrtc_ref_t;

    typedef struct packed {
        logic [31:0] data;
        logic [31:0] rdata;
        logic [31:0] prdata;
        logic [1:0] addr;
        logic write;
        logic req;
        logic [1:0] sts;
        logic [1:0] mask;
        logic ref_en;
        logic [3:0] left;
        logic [1:0] gap;
        logic cmd;
        logic done;
        sdrtc_ref_t st;
    } sdrtc_ctl_state_t;

    sdrtc_ctl_state_t s_q;
    sdrtc_ctl_state_t s_d;
    logic setup;
    logic wr_acc;
    logic mapped;

    // ==========================================================
    // next state
    always_comb
    begin
        s_d = s_q;
        s_d.cmd = 1'b0;
        s_d.done = 1'b0;
        setup = PSEL && !PENABLE;
        wr_acc = PSEL && PENABLE && PWRITE;
        mapped = (PADDR == OFS_DATA) || (PADDR == OFS_CMD) || (PADDR == OFS_RDATA)
            || (PADDR == OFS_STATUS) || (PADDR == OFS_MASK) || (PADDR == OFS_CTRL);

        if (setup)
        begin
            if (PADDR == OFS_DATA)
                s_d.prdata = s_q.data;
            else if (PADDR == OFS_RDATA)
                s_d.prdata = s_q.rdata;
            else if (PADDR == OFS_STATUS)
                s_d.prdata = {29'h0, s_q.req, s_q.sts};
            else if (PADDR == OFS_MASK)
                s_d.prdata = {30'h0, s_q.mask};
            else if (PADDR == OFS_CTRL)
                s_d.prdata = {31'h0, s_q.ref_en};
            else
                s_d.prdata = 32'h0000_0000;
        end

        // link transfer ends when the timer acks
        if (s_q.req && LINK.ack)
        begin
            s_d.req = 1'b0;
            if (!s_q.write)
                s_d.rdata = LINK.rdata;
        end

        if (wr_acc)
        begin
            if (PADDR == OFS_DATA)
                s_d.data = PWDATA;
            else if (PADDR == OFS_CMD && !s_q.req)
            begin
                // a command while busy is dropped; software polls the busy bit
                s_d.addr = PWDATA[1:0];
                s_d.write = PWDATA[CMD_WRITE_BIT];
                s_d.req = 1'b1;
            end
            else if (PADDR == OFS_STATUS)
                s_d.sts = s_q.sts & ~PWDATA[1:0];
            else if (PADDR == OFS_MASK)
                s_d.mask = PWDATA[1:0];
            else if (PADDR == OFS_CTRL)
                s_d.ref_en = PWDATA[0];
        end

        // refresh burst: one command, then a gap, per requested cycle
        case (s_q.st)
            R_IDLE:
            begin
                if (LINK.refresh_req)
                begin
                    s_d.left = LINK.burst_len;
                    s_d.st = R_CMD;
                end
            end
            R_CMD:
            begin
                s_d.cmd = 1'b1;
                s_d.left = s_q.left - 4'h1;
                s_d.gap = REF_GAP_CYC - 2'h1;
                s_d.st = R_GAP;
            end
            R_GAP:
            begin
                if (s_q.gap != 2'h0)
                    s_d.gap = s_q.gap - 2'h1;
                else if (s_q.left != 4'h0)
                    s_d.st = R_CMD;
                else
                begin
                    s_d.done = 1'b1;
                    s_d.st = R_DONE;
                end
            end
            default:
                s_d.st = R_IDLE;
        endcase

        // events set after the clear so that a set wins
        if (s_q.req && LINK.ack)
            s_d.sts[STS_XFER] = 1'b1;
        if (s_q.st == R_GAP && s_d.st == R_DONE)
            s_d.sts[STS_REFRESH] = 1'b1;
    end

    // ==========================================================
    // registers
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign PRDATA = s_q.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign IRQ = |(s_q.sts & s_q.mask);
    assign SDRAM_REFRESH_CMD = s_q.cmd;
    assign BURST_LEN = LINK.burst_len;
    assign LINK.req = s_q.req;
    assign LINK.write = s_q.write;
    assign LINK.addr = s_q.addr;
    assign LINK.wdata = s_q.data;
    assign LINK.refresh_enable = s_q.ref_en;
    assign LINK.refresh_done = s_q.done;

endmodule // sdrtc_ctrl

// ### rtl/sdrtc_timer.sv
// refresh timer end: control/status register, tick counter, time constant, refresh request
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
//
// Summary of operation
// RULE1: power-on reset zeroes register; nothing else does
// RULE2: writes take effect only with key above
// RULE3: prescaler phase set only at power-on reset
// RULE4: bits 31 to 8 always read zero
// RULE5: bit 6 reads zero; software writes zero
// RULE6: match flag sets when counter equals constant
// RULE7: flag clears by zero write after read
// RULE8: clock select stops or divides bus clock
// RULE9: burst code gives one to eight refreshes
// RULE10: software avoids burst codes 101 to 111
// RULE11: counter ticks, clears on match, wraps
// RULE12: match raises one pending refresh request
// RULE13: keyless write changes nothing at all
module sdrtc_timer
(
    // clock and power-on reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // link to the controller
    sdrtc_if.dev LINK,
    // status toward the unit
    output logic CMP_MATCH,
    output logic REFRESH_PENDING,
    output sdrtc_pkg::sdrtc_byte_t TICK_COUNT
);
    import sdrtc_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic compare_match_flag;
        // armed by a read that saw the flag set; only then may a zero write clear it
        logic cmf_seen;
        logic [2:0] cks;
        logic [2:0] rrc;
        logic [7:0] cnt;
        logic [7:0] cor;
        logic [11:0] pre;
        logic pend;
        logic match;
        logic ack;
        logic [31:0] rdata;
    } sdrtc_dev_state_t;

    sdrtc_dev_state_t s_q;
    sdrtc_dev_state_t s_d;
    logic take;
    logic key_ok;
    logic tick;
    logic hit;

    // ==========================================================
    // helpers
    function automatic logic [11:0] div_mask(input logic [2:0] sel);
        case (sel)
            3'h1: return DIV_4;
            3'h2: return DIV_16;
            3'h3: return DIV_64;
            3'h4: return DIV_256;
            3'h5: return DIV_1024;
            3'h6: return DIV_2048;
            3'h7: return DIV_4096;
            default: return DIV_STOP;
        endcase
    endfunction

    // the narrow registers read back with their reserved bits as zero
    function automatic logic [31:0] byte_word(input sdrtc_byte_t b);
        return {24'h00_0000, b};
    endfunction

    // csr image as software sees it
    function automatic logic [31:0] csr_image(input sdrtc_dev_state_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[CMF_BIT] = s.compare_match_flag;
        v[CKS_LSB+2:CKS_LSB] = s.cks;
        v[RRC_LSB+2:RRC_LSB] = s.rrc;
        return v;
    endfunction

    // ==========================================================
    // next state
    always_comb
    begin
        s_d = s_q;
        s_d.match = 1'b0;
        s_d.ack = 1'b0;
        // ack is registered, so a request still held in its ack cycle is not taken twice
        take = LINK.req && !s_q.ack;
        key_ok = (LINK.wdata[KEY_MSB:KEY_LSB] == WRITE_KEY); // RULE2
        // the prescaler never restarts, so a fresh select may give a short first interval
        s_d.pre = s_q.pre + 12'h001; // RULE3
        tick = (s_q.cks != 3'h0) && ((s_q.pre & div_mask(s_q.cks)) == div_mask(s_q.cks)); // RULE8
        // a match needs a tick, so a stopped counter never matches
        hit = tick && (s_q.cnt == s_q.cor);

        if (hit)
        begin
            s_d.cnt = BYTE_RESET; // RULE11
            s_d.match = 1'b1;
        end
        else if (tick)
        begin
            s_d.cnt = s_q.cnt + 8'h01; // RULE11
        end

        if (take)
        begin
            s_d.ack = 1'b1;
            if (LINK.write)
            begin
                // a keyless write is still acked so the controller never waits on it
                if (key_ok) // RULE13
                begin
                    if (LINK.addr == REG_CSR)
                    begin
                        s_d.cks = LINK.wdata[CKS_LSB+2:CKS_LSB]; // RULE8
                        s_d.rrc = LINK.wdata[RRC_LSB+2:RRC_LSB]; // RULE9
                        // writing one never sets the flag
                        if (!LINK.wdata[CMF_BIT] && s_q.cmf_seen)
                        begin
                            s_d.compare_match_flag = 1'b0; // RULE7
                            s_d.cmf_seen = 1'b0;
                        end
                    end
                    else if (LINK.addr == REG_CNT)
                    begin
                        // a counter write in a tick cycle wins over the increment
                        s_d.cnt = LINK.wdata[7:0];
                    end
                    else if (LINK.addr == REG_COR)
                    begin
                        s_d.cor = LINK.wdata[7:0];
                    end
                end
            end
            else
            begin
                if (LINK.addr == REG_CSR)
                begin
                    s_d.rdata = csr_image(s_q); // RULE4 RULE5
                    if (s_q.compare_match_flag)
                    begin
                        s_d.cmf_seen = 1'b1; // RULE7
                    end
                end
                else if (LINK.addr == REG_CNT)
                begin
                    s_d.rdata = byte_word(s_q.cnt); // RULE4
                end
                else if (LINK.addr == REG_COR)
                begin
                    s_d.rdata = byte_word(s_q.cor); // RULE4
                end
                else
                begin
                    // index 3 is unmapped: it reads zero and ignores writes
                    s_d.rdata = 32'h0000_0000;
                end
            end
        end

        // a match in the clearing cycle keeps the flag set
        if (hit)
        begin
            s_d.compare_match_flag = 1'b1; // RULE6
        end

        // a further match while pending does not stack a second request
        if (LINK.refresh_done)
        begin
            s_d.pend = 1'b0;
        end
        if (hit && LINK.refresh_enable)
        begin
            s_d.pend = 1'b1; // RULE12
        end
    end

    // ==========================================================
    // registers; only power-on reset clears them
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            s_q <= '0; // RULE1
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign LINK.rdata = s_q.rdata;
    assign LINK.ack = s_q.ack;
    assign LINK.refresh_req = s_q.pend;
    // decoded here so the sequencer keeps no copy of the burst code
    assign LINK.burst_len = sdrtc_burst_len(s_q.rrc); // RULE9
    assign CMP_MATCH = s_q.match;
    assign REFRESH_PENDING = s_q.pend;
    assign TICK_COUNT = s_q.cnt;

endmodule // sdrtc_timer

// ### tb/sdram_refresh_timer_ctrl_test.sv
// self-checking bench for the refresh timer and its controller
`timescale 1ns/1ps
module sdram_refresh_timer_ctrl_test;
    import sdrtc_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic ref_cmd;
    logic cmp_match;
    logic pending;
    sdrtc_byte_t tick;
    sdrtc_burst_t burst;
    logic [31:0] r;
    logic err;
    int fail_count = 0;
    int checked = 0;

    sdrtc_if sdrtc_if_i ();
    sdrtc_timer sdrtc_timer_i (.CORE_CLK(core_clk), .NRST(nrst), .LINK(sdrtc_if_i.dev),
        .CMP_MATCH(cmp_match), .REFRESH_PENDING(pending), .TICK_COUNT(tick));
    sdrtc_ctrl sdrtc_ctrl_i (.CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IRQ(irq), .SDRAM_REFRESH_CMD(ref_cmd), .LINK(sdrtc_if_i.ctl),
        .BURST_LEN(burst));
    sdrtc_assertions sdrtc_assertions_i (.CORE_CLK(core_clk), .NRST(nrst),
        .req(sdrtc_if_i.req), .write(sdrtc_if_i.write), .addr(sdrtc_if_i.addr),
        .wdata(sdrtc_if_i.wdata), .rdata(sdrtc_if_i.rdata), .ack(sdrtc_if_i.ack),
        .refresh_enable(sdrtc_if_i.refresh_enable), .refresh_req(sdrtc_if_i.refresh_req),
        .burst_len(sdrtc_if_i.burst_len), .refresh_done(sdrtc_if_i.refresh_done));

    initial
        forever #25 core_clk = ~core_clk;

    // ====
    // shared tasks
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // one link transfer through the controller, read result left in r
    task automatic link(input logic w, input logic [1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb(1'b1, OFS_DATA, d);
        apb(1'b1, OFS_CMD, {23'h0, w, 6'h0, a});
        do
        begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end
        while (r[STS_XFER] !== 1'b1 && n < 20);
        check("transfer done", 1'b1, r[STS_XFER]);
        apb(1'b1, OFS_STATUS, 32'h1);
        if (!w)
            apb(1'b0, OFS_RDATA, 32'h0);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        link(1'b1, a, {WRITE_KEY, 8'h00, v});
    endtask

    // cycles between two changes of the tick counter, counted at falling edges
    task automatic gap(output int n);
        sdrtc_byte_t v;
        v = tick;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (tick === v && n < 5000);
        @(posedge core_clk);
    endtask

    // ====
    // scenarios
    task automatic t_reset;
        for (int a = 0; a < 3; a++)
        begin
            link(1'b0, 2'(a), 32'h0);
            check("reset value", 32'h0, r);
        end
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", 1'b1, err);
    endtask

    task automatic t_key;
        link(1'b1, REG_CSR, 32'h0000_ff3c);
        link(1'b0, REG_CSR, 32'h0);
        check("keyless write", 32'h0, r);
        link(1'b1, REG_CSR, {WRITE_KEY, 16'hff3c});
        link(1'b0, REG_CSR, 32'h0);
        check("keyed write", 32'h3c, r);
    endtask

    task automatic t_burst;
        for (int c = 0; c < 5; c++)
        begin
            wr(REG_CSR, 8'(c));
            check("burst length", (c == 0) ? 1 : 2 * c, burst);
        end
    endtask

    task automatic t_cks;
        int n;
        sdrtc_byte_t v;
        wr(REG_COR, 8'hff);
        for (int c = 1; c < 8; c++)
        begin
            wr(REG_CSR, {2'b00, 3'(c), 3'h0});
            gap(n);
            gap(n);
            check("tick period", (c <= 5) ? (4 << (2 * c - 2)) : (1 << (c + 5)), n);
        end
        wr(REG_CSR, 8'h00);
        v = tick;
        repeat (300) @(posedge core_clk);
        check("stopped counter", v, tick);
    endtask

    task automatic t_flag;
        int n;
        link(1'b0, REG_CSR, 32'h0);
        wr(REG_CSR, 8'h00);
        link(1'b0, REG_CSR, 32'h0);
        check("flag cleared", 32'h0, r);
        wr(REG_COR, 8'h03);
        wr(REG_CNT, 8'h00);
        wr(REG_CSR, 8'h08);
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (cmp_match !== 1'b1 && n < 100);
        check("counter after match", 8'h00, tick);
        check("pending while disabled", 1'b0, pending);
        @(posedge core_clk);
        wr(REG_CSR, 8'h00);
        link(1'b0, REG_CSR, 32'h0);
        check("flag kept without read", 32'h80, r);
        wr(REG_CSR, 8'h00);
        link(1'b0, REG_CSR, 32'h0);
        check("flag cleared after read", 32'h0, r);
    endtask

    task automatic t_refresh;
        int n;
        int k;
        n = 0;
        k = 0;
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_MASK, 32'h2);
        // start from zero so the first match falls after the counting loop begins
        wr(REG_CNT, 8'h00);
        wr(REG_CSR, 8'h0a);
        while (irq !== 1'b1 && n < 300)
        begin
            @(negedge core_clk);
            n++;
            if (ref_cmd === 1'b1)
                k++;
        end
        @(posedge core_clk);
        check("refresh commands", 4, k);
        wr(REG_CSR, 8'h00);
        // let any burst queued before the stop run out
        repeat (100) @(posedge core_clk);
        apb(1'b1, OFS_MASK, 32'h0);
        check("masked irq", 1'b0, irq);
        apb(1'b1, OFS_MASK, 32'h2);
        check("raised irq", 1'b1, irq);
        apb(1'b1, OFS_STATUS, 32'h2);
        check("cleared irq", 1'b0, irq);
    endtask

    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #4_000_000;
        fail_count++;
        conclude;
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_reset;
        t_key;
        t_burst;
        t_cks;
        t_flag;
        t_refresh;
        conclude;
    end
endmodule // sdram_refresh_timer_ctrl_test

// ### tb/sdrtc_assertions.sv
// concurrent checks on the link between timer and controller
`timescale 1ns/1ps
module sdrtc_assertions
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // link signals
    input wire logic req,
    input wire logic write,
    input wire logic [1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic ack,
    input wire logic refresh_enable,
    input wire logic refresh_req,
    input wire logic [3:0] burst_len,
    input wire logic refresh_done
);
    import sdrtc_pkg::*;
    logic take;
    logic keyed;
    logic [3:0] want_q;
    assign take = req && !ack;
    assign keyed = wdata[31:16] == WRITE_KEY;
    // ====
    // expected burst length, kept from the last keyed control write
    always_ff @(posedge CORE_CLK or negedge NRST)
        if (!NRST)
            want_q <= 4'h1;
        else if (take && write && keyed && addr == REG_CSR)
            want_q <= (wdata[2:0] inside {[3'h1:3'h4]}) ? {wdata[2:0], 1'b0} : 4'h1;
    // ====
    // properties
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    chk_ack_after_take: assert property (take |=> ack)
        else $error("link ack missing after request");
    chk_ack_one_pulse: assert property (ack |=> !ack)
        else $error("link ack longer than one cycle");
    chk_high_bits_zero: assert property (ack && !write |-> rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_bit_six_zero: assert property (ack && !write && addr == REG_CSR |-> !rdata[6])
        else $error("bit six reads one");
    chk_burst_decode: assert property (take && write && keyed && addr == REG_CSR |-> ##2 burst_len == want_q)
        else $error("burst length wrong after write");
    chk_keyless_stable: assert property (take && write && !keyed |=> $stable(burst_len) [*2])
        else $error("keyless write changed burst length");
    chk_pending_holds: assert property (refresh_req && !refresh_done |=> refresh_req)
        else $error("refresh request dropped unserviced");
    chk_pending_enable: assert property ($rose(refresh_req) |-> $past(refresh_enable))
        else $error("refresh request while disabled");
    chk_done_pending: assert property (refresh_done |-> refresh_req)
        else $error("refresh done with nothing pending");
    cover property (take && write && keyed && addr == REG_CSR);
    cover property ($rose(refresh_req));
    cover property (refresh_done);
endmodule // sdrtc_assertions
